// *** eef_top.sv ***
// Edge enhancement filter stage with AXI4-Lite settings
// Behaviour
// - Enhancement is off after reset until software sets the enable.
// - With enable off pixels pass unchanged and the other settings are ignored.
// - Only pixels whose local gradient exceeds the active threshold are altered.
// - The threshold is a fraction of full range from 0 to 0.25, larger values act as 0.25.
// - With auto off the software threshold is the active one.
// - With auto on the threshold is derived from the measured noise level.
// - Zero amount changes nothing, negative smooths, positive boosts edges.
// - The adjustment is the pixel-to-neighbour difference scaled by the amount.
// - The amount is limited to a boost of 8x and a smoothing of 1x.
// - The amount holds 2.0 after reset.
`timescale 1ns/1ps
module eef_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] noise_level,
  input wire logic [7:0] s_pix_data,
  input wire logic s_pix_last,
  input wire logic s_pix_valid,
  output logic s_pix_ready,
  output logic [7:0] m_pix_data,
  output logic m_pix_last,
  output logic m_pix_valid,
  input wire logic m_pix_ready
);
  typedef enum logic [1:0] {EEF_FILL, EEF_RUN, EEF_FLUSH} eef_state_t;

  // Settings
  logic ctrl_en;
  logic ctrl_auto;
  logic [10:0] thr_reg;
  logic signed [15:0] amt;

  // Write channel state
  logic aw_held;
  logic [11:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;

  // Window state
  eef_state_t state;
  eef_state_t next_state;
  logic [7:0] left;
  logic [7:0] cen;

  eef_stream_if #(.W(eef_pkg::TOK_W)) push_if ();
  eef_stream_if #(.W(eef_pkg::TOK_W)) pop_if ();

  function automatic logic [31:0] eef_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] strb);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) res[8*i +: 8] = nw[8*i +: 8];
    end
    return res;
  endfunction : eef_merge

  // Active threshold
  logic [10:0] thr_auto_raw;
  logic [10:0] thr_sel;
  logic [10:0] thr_active;
  // Twice the noise level, as a fraction in the same steps as the manual threshold
  assign thr_auto_raw = 11'(noise_level) << eef_pkg::NOISE_SHIFT;
  assign thr_sel = ctrl_auto ? thr_auto_raw : thr_reg;
  assign thr_active = (thr_sel > eef_pkg::THR_MAX) ? eef_pkg::THR_MAX : thr_sel;

  // Register decode
  logic [31:0] ctrl_word;
  logic [31:0] thr_word;
  logic [31:0] amt_word;
  logic [31:0] stat_word;
  logic wr_go;
  logic wr_ctrl;
  logic wr_thr;
  logic wr_amt;
  logic wr_hit;
  logic [31:0] ctrl_new;
  logic [31:0] thr_new;
  logic [31:0] amt_new;
  logic signed [15:0] amt_req;
  logic signed [15:0] amt_lim;
  logic rd_hit;
  logic [31:0] rd_word;
  assign ctrl_word = {30'h0, ctrl_auto, ctrl_en};
  assign thr_word = {21'h0, thr_reg};
  assign amt_word = {16'h0, amt};
  assign stat_word = {15'h0, state == EEF_FLUSH, 5'h0, thr_active};
  assign wr_go = aw_held && w_held && !s_axi_bvalid;
  assign wr_ctrl = aw_addr == eef_pkg::OFS_CTRL;
  assign wr_thr = aw_addr == eef_pkg::OFS_THRESH;
  assign wr_amt = aw_addr == eef_pkg::OFS_AMOUNT;
  assign wr_hit = wr_ctrl || wr_thr || wr_amt || (aw_addr == eef_pkg::OFS_STATUS);
  assign ctrl_new = eef_merge(ctrl_word, w_data, w_strb);
  assign thr_new = eef_merge(thr_word, w_data, w_strb);
  assign amt_new = eef_merge(amt_word, w_data, w_strb);
  assign amt_req = $signed(amt_new[15:0]);
  // Out-of-range amounts are pinned so software reads back what is applied
  assign amt_lim = (amt_req > eef_pkg::AMT_MAX) ? eef_pkg::AMT_MAX :
                   (amt_req < eef_pkg::AMT_MIN) ? eef_pkg::AMT_MIN : amt_req;
  assign rd_hit = (s_axi_araddr == eef_pkg::OFS_CTRL) || (s_axi_araddr == eef_pkg::OFS_THRESH) ||
                  (s_axi_araddr == eef_pkg::OFS_AMOUNT) || (s_axi_araddr == eef_pkg::OFS_STATUS);
  assign rd_word = (s_axi_araddr == eef_pkg::OFS_CTRL) ? ctrl_word :
                   (s_axi_araddr == eef_pkg::OFS_THRESH) ? thr_word :
                   (s_axi_araddr == eef_pkg::OFS_AMOUNT) ? amt_word :
                   (s_axi_araddr == eef_pkg::OFS_STATUS) ? stat_word : 32'h0;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      aw_addr <= 12'h000;
      w_data <= 32'h0;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= eef_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? eef_pkg::RESP_OKAY : eef_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_en <= 1'b0;
      ctrl_auto <= 1'b0;
      thr_reg <= eef_pkg::THR_RST;
      amt <= eef_pkg::AMT_RST;
    end else if (wr_go) begin
      if (wr_ctrl) begin
        ctrl_en <= ctrl_new[eef_pkg::CTRL_EN_BIT];
        ctrl_auto <= ctrl_new[eef_pkg::CTRL_AUTO_BIT];
      end
      if (wr_thr) thr_reg <= thr_new[10:0];
      if (wr_amt) amt <= amt_lim;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= eef_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? eef_pkg::RESP_OKAY : eef_pkg::RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // Three-tap window; line ends replicate the edge pixel
  logic in_fire;
  logic [7:0] right;
  logic [7:0] core_out;
  logic [7:0] core_mean;
  logic core_hit;
  assign s_pix_ready = push_if.ready && (state != EEF_FLUSH);
  assign in_fire = s_pix_valid && s_pix_ready;
  assign right = (state == EEF_FLUSH) ? cen : s_pix_data;
  assign push_if.valid = (state == EEF_FLUSH) || ((state == EEF_RUN) && s_pix_valid);
  assign push_if.data = {state == EEF_FLUSH, core_out};

  eef_core u_core (
    .left(left),
    .cen(cen),
    .right(right),
    .enable(ctrl_en),
    .thr(thr_active),
    .amt(amt),
    .result(core_out),
    .mean(core_mean),
    .hit(core_hit)
  );

  always_comb begin
    next_state = state;
    case (state)
      EEF_FILL: if (in_fire) next_state = s_pix_last ? EEF_FLUSH : EEF_RUN;
      EEF_RUN: if (in_fire) next_state = s_pix_last ? EEF_FLUSH : EEF_RUN;
      EEF_FLUSH: if (push_if.ready) next_state = EEF_FILL;
      default: next_state = EEF_FILL;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state <= EEF_FILL;
      left <= 8'h00;
      cen <= 8'h00;
    end else begin
      state <= next_state;
      if (in_fire) begin
        left <= (state == EEF_FILL) ? s_pix_data : cen;
        cen <= s_pix_data;
      end
    end
  end

  eef_fifo #(.WIDTH(eef_pkg::TOK_W), .DEPTH(eef_pkg::FIFO_DEPTH)) u_fifo (
    .aclk(aclk),
    .aresetn(aresetn),
    .wr(push_if),
    .rd(pop_if)
  );

  assign m_pix_data = pop_if.data[7:0];
  assign m_pix_last = pop_if.data[8];
  assign m_pix_valid = pop_if.valid;
  assign pop_if.ready = m_pix_ready;

  // Checks
  logic push;
  assign push = push_if.valid && push_if.ready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_reset_off;
    $rose(aresetn) |-> !ctrl_en ##1 (!ctrl_en || $past(wr_go));
  endproperty
  a_reset_off: assert property (p_reset_off) else $error("enable not off after reset");

  property p_bypass;
    push && !ctrl_en |-> push_if.data[7:0] == cen;
  endproperty
  a_bypass: assert property (p_bypass) else $error("pixel altered while disabled");

  property p_below_thr;
    push && !core_hit |-> push_if.data[7:0] == cen;
  endproperty
  a_below_thr: assert property (p_below_thr) else $error("smooth pixel altered");

  property p_thr_cap;
    (thr_active <= eef_pkg::THR_MAX) and
      (thr_sel > eef_pkg::THR_MAX |-> thr_active == eef_pkg::THR_MAX);
  endproperty
  a_thr_cap: assert property (p_thr_cap) else $error("threshold above quarter range");

  property p_manual_thr;
    !ctrl_auto && thr_reg <= eef_pkg::THR_MAX |-> thr_active == thr_reg;
  endproperty
  a_manual_thr: assert property (p_manual_thr) else $error("manual threshold not used");

  property p_auto_thr;
    ctrl_auto && noise_level < 8'h20 |-> thr_active == {noise_level, 3'h0};
  endproperty
  a_auto_thr: assert property (p_auto_thr) else $error("auto threshold not from noise");

  property p_zero_amt;
    push && amt == 16'sh0000 |-> push_if.data[7:0] == cen;
  endproperty
  a_zero_amt: assert property (p_zero_amt) else $error("zero amount changed pixel");

  property p_full_smooth;
    push && ctrl_en && core_hit && amt == eef_pkg::AMT_MIN |-> push_if.data[7:0] == core_mean;
  endproperty
  a_full_smooth: assert property (p_full_smooth) else $error("1x smoothing not the mean");

  property p_amt_range;
    amt <= eef_pkg::AMT_MAX && amt >= eef_pkg::AMT_MIN;
  endproperty
  a_amt_range: assert property (p_amt_range) else $error("amount out of range");

  property p_amt_reset;
    $rose(aresetn) |-> amt == 16'sh0200;
  endproperty
  a_amt_reset: assert property (p_amt_reset) else $error("amount not 2.0 after reset");

  property p_out_hold;
    m_pix_valid && !m_pix_ready |=> m_pix_valid && $stable(m_pix_data) && $stable(m_pix_last);
  endproperty
  a_out_hold: assert property (p_out_hold) else $error("output dropped under stall");
endmodule : eef_top

// *** eef_pkg.sv ***
// Constants shared by the edge enhancement filter files
package eef_pkg;
  localparam int PIX_W = 8;
  localparam int TOK_W = 9;
  localparam int FIFO_DEPTH = 4;
  localparam int ADDR_W = 12;
  // Register byte offsets
  localparam logic [11:0] OFS_CTRL = 12'h000;
  localparam logic [11:0] OFS_THRESH = 12'h004;
  localparam logic [11:0] OFS_AMOUNT = 12'h008;
  localparam logic [11:0] OFS_STATUS = 12'h00C;
  // Field positions
  localparam int CTRL_EN_BIT = 0;
  localparam int CTRL_AUTO_BIT = 1;
  localparam int STAT_BUSY_BIT = 16;
  localparam int THR_W = 11;
  localparam int AMT_W = 16;
  // Threshold is a fraction in 1/1024 steps; 0x100 is one quarter of full range
  localparam logic [10:0] THR_MAX = 11'h100;
  localparam logic [10:0] THR_RST = 11'h010;
  // Auto threshold is twice the noise level, noise in pixel codes
  localparam int NOISE_SHIFT = 3;
  // Gradient in pixel codes to 1/1024 fraction
  localparam int FRAC_SHIFT = 2;
  // Amount is signed with 8 fraction bits
  localparam int AMT_FRAC = 8;
  localparam logic signed [15:0] AMT_MAX = 16'sh0800;
  localparam logic signed [15:0] AMT_MIN = 16'shFF00;
  localparam logic signed [15:0] AMT_RST = 16'sh0200;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : eef_pkg

// *** eef_stream_if.sv ***
// Valid/ready token stream between filter stages
`timescale 1ns/1ps
interface eef_stream_if #(parameter int W = 9);
  logic [W-1:0] data;
  logic valid;
  logic ready;
  modport tx (output data, output valid, input ready);
  modport rx (input data, input valid, output ready);
endinterface : eef_stream_if

// *** eef_fifo.sv ***
// Small register FIFO for filtered pixels
`timescale 1ns/1ps
module eef_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 4
) (
  input wire logic aclk,
  input wire logic aresetn,
  eef_stream_if.rx wr,
  eef_stream_if.tx rd
);
  localparam int PW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [PW:0] wp;
  logic [PW:0] rp;
  logic full;
  logic empty;
  logic push;
  logic pop;

  assign empty = (wp == rp);
  assign full = (wp[PW-1:0] == rp[PW-1:0]) && (wp[PW] != rp[PW]);
  assign wr.ready = !full;
  assign rd.valid = !empty;
  assign rd.data = mem[rp[PW-1:0]];
  assign push = wr.valid && !full;
  assign pop = rd.ready && !empty;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wp <= '0;
      rp <= '0;
    end else begin
      if (push) wp <= wp + 1'b1;
      if (pop) rp <= rp + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (push) mem[wp[PW-1:0]] <= wr.data;
  end
endmodule : eef_fifo

// *** eef_core.sv ***
// Per-pixel gradient test and sharpen or smooth arithmetic
`timescale 1ns/1ps
module eef_core (
  input wire logic [7:0] left,
  input wire logic [7:0] cen,
  input wire logic [7:0] right,
  input wire logic enable,
  input wire logic [10:0] thr,
  input wire logic signed [15:0] amt,
  output logic [7:0] result,
  output logic [7:0] mean,
  output logic hit
);
  logic [8:0] nsum;
  logic signed [9:0] diff;
  logic [9:0] grad;
  logic [11:0] grad_frac;
  logic signed [25:0] prod;
  logic signed [25:0] adj;
  logic signed [26:0] sum;
  logic [7:0] sat;

  assign nsum = {1'b0, left} + {1'b0, right};
  assign mean = nsum[8:1];
  assign diff = $signed({2'h0, cen}) - $signed({2'h0, mean});
  assign grad = diff[9] ? 10'(-diff) : 10'(diff);
  assign grad_frac = 12'(grad) << eef_pkg::FRAC_SHIFT;
  assign hit = grad_frac > {1'h0, thr};
  assign prod = diff * amt;
  assign adj = prod >>> eef_pkg::AMT_FRAC;
  assign sum = $signed({19'h0, cen}) + 27'(adj);
  // Clamp keeps heavy boosts from wrapping around
  assign sat = sum[26] ? 8'h00 : (|sum[25:8]) ? 8'hFF : sum[7:0];
  assign result = (enable && hit) ? sat : cen;
endmodule : eef_core

// *** eef_stage_model.sv ***
// Upstream pixel source and downstream pixel sink around the filter
`timescale 1ns/1ps
module eef_stage_model (
  input wire logic aclk,
  input wire logic [1:0] mode,
  output logic [7:0] s_pix_data,
  output logic s_pix_last,
  output logic s_pix_valid,
  input wire logic s_pix_ready,
  output logic m_pix_ready
);
  initial begin
    s_pix_data = 8'h00;
    s_pix_last = 1'b0;
    s_pix_valid = 1'b0;
  end
  // Mode 0 always ready, mode 1 random stalls, mode 2 held off to fill the buffer
  always @(posedge aclk) begin
    m_pix_ready <= (mode == 2'h0) ? 1'b1 : (mode == 2'h1) ? 1'($urandom_range(1)) : 1'b0;
  end
  // Valid drops between pixels only for a random gap of whole cycles in mode 1, so no double assignment at one edge
  task automatic push(input logic [7:0] d, input logic l);
    int gap;
    gap = (mode == 2'h1) ? $urandom_range(2) : 0;
    if (gap > 0) begin
      s_pix_valid <= 1'b0;
      repeat (gap) @(posedge aclk);
    end
    s_pix_data <= d;
    s_pix_last <= l;
    s_pix_valid <= 1'b1;
    do @(posedge aclk); while (s_pix_ready !== 1'b1);
  endtask : push
  // Released lines show the inverse so stale data never looks valid
  task automatic idle();
    s_pix_valid <= 1'b0;
    s_pix_data <= ~s_pix_data;
    s_pix_last <= ~s_pix_last;
  endtask : idle
endmodule : eef_stage_model

// *** eef_top_tb_top.sv ***
// Self-checking bench for the edge enhancement filter
`timescale 1ns/1ps
module eef_top_tb_top;
  logic aclk, aresetn;
  logic [11:0] s_axi_awaddr, s_axi_araddr;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0] s_axi_wstrb;
  logic [1:0] s_axi_bresp, s_axi_rresp, mode;
  logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [7:0] noise_level, s_pix_data, m_pix_data;
  logic s_pix_last, s_pix_valid, s_pix_ready, m_pix_last, m_pix_valid, m_pix_ready;
  int failures = 0, check_count = 0, cyc = 0, en = 0, thr_a = 16, amt_a = 512;
  logic [8:0] exq[$];
  logic [31:0] d;
  logic [1:0] r;
  logic [15:0] amt_w[7] = '{16'h0000, 16'h0100, 16'hFF00, 16'h7FFF, 16'h8000, 16'hFF80, 16'h0200};
  int thr_l[3] = '{0, 128, 2047};

  eef_top dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .noise_level, .s_pix_data, .s_pix_last, .s_pix_valid, .s_pix_ready,
    .m_pix_data, .m_pix_last, .m_pix_valid, .m_pix_ready);
  eef_stage_model u_part (.aclk, .mode, .s_pix_data, .s_pix_last, .s_pix_valid, .s_pix_ready,
    .m_pix_ready);

  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic check(input string n, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : give_verdict

  // Cuts a hang short well past the expected run length
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      give_verdict();
    end
  end

  task automatic wr(input logic [11:0] a, input logic [31:0] v, output logic [1:0] rs);
    bit ad, wd;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_awvalid <= 1'b1;
    s_axi_wdata <= v;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    ad = 0;
    wd = 0;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin
        ad = 1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wd && s_axi_wready === 1'b1) begin
        wd = 1;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (s_axi_bvalid !== 1'b1) @(posedge aclk);
    rs = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [11:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge aclk);
    v = s_axi_rdata;
    rs = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask : rd

  // Reference arithmetic kept apart from the design's own
  function automatic logic [7:0] ex(input int l, input int c, input int rt);
    int dd, o;
    dd = c - ((l + rt) >>> 1);
    o = c;
    if (en != 0 && ((dd < 0) ? -dd : dd) * 4 > thr_a) o = c + ((dd * amt_a) >>> 8);
    return 8'((o < 0) ? 0 : (o > 255) ? 255 : o);
  endfunction : ex

  task automatic send_line(input int n);
    logic [7:0] p[$];
    for (int i = 0; i < n; i++) p.push_back(8'($urandom_range(255)));
    for (int i = 0; i < n; i++)
      exq.push_back({i == n - 1, ex(p[(i == 0) ? 0 : i - 1], p[i], p[(i == n - 1) ? i : i + 1])});
    for (int i = 0; i < n; i++) u_part.push(p[i], i == n - 1);
    u_part.idle();
    for (int k = 0; k < 300 && exq.size() != 0; k++) @(posedge aclk);
    check("pending pixels", 32'(exq.size()), 32'h0);
  endtask : send_line

  always @(posedge aclk) begin
    if (aresetn === 1'b1 && m_pix_valid === 1'b1 && m_pix_ready === 1'b1) begin
      if (exq.size() == 0) check("extra pixel", 32'h1, 32'h0);
      else check("pixel", {23'h0, m_pix_last, m_pix_data}, {23'h0, exq.pop_front()});
    end
  end

  initial begin
    int nz;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    s_axi_wstrb = 4'hF;
    noise_level = 8'h00;
    mode = 2'h0;
    aresetn = 1'b0;
    void'($urandom(32'hB226));
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    rd(12'h000, d, r);
    check("ctrl", d, 32'h0);
    check("mapped rresp", {30'h0, r}, 32'h0);
    rd(12'h008, d, r);
    check("amount", d, 32'h0000_0200);
    rd(12'h00C, d, r);
    check("active thr", d & 32'h7FF, 32'h010);
    rd(12'h010, d, r);
    check("unmapped rresp", {30'h0, r}, 32'h2);
    wr(12'h010, 32'h1, r);
    check("unmapped bresp", {30'h0, r}, 32'h2);
    // Strong amount while disabled must not alter pixels
    wr(12'h008, 32'h0800, r);
    check("mapped bresp", {30'h0, r}, 32'h0);
    wr(12'h004, 32'h0, r);
    mode = 2'h1;
    send_line(6);
    for (int i = 0; i < 7; i++) begin
      nz = $urandom_range(40);
      noise_level <= 8'(nz);
      wr(12'h004, 32'(thr_l[i % 3]), r);
      wr(12'h008, {16'h0, amt_w[i]}, r);
      wr(12'h000, {30'h0, i >= 5, 1'b1}, r);
      en = 1;
      amt_a = int'($signed(amt_w[i]));
      amt_a = (amt_a > 2048) ? 2048 : (amt_a < -256) ? -256 : amt_a;
      thr_a = (i >= 5) ? nz * 8 : thr_l[i % 3];
      thr_a = (thr_a > 256) ? 256 : thr_a;
      rd(12'h008, d, r);
      check("amount clamp", d, 32'(amt_a) & 32'hFFFF);
      rd(12'h00C, d, r);
      check("active thr", d & 32'h7FF, 32'(thr_a));
      mode = 2'(i % 2);
      send_line(7);
    end
    // Sink held off: the 4-deep buffer fills and input is refused
    mode = 2'h2;
    fork
      send_line(8);
      begin
        repeat (40) @(posedge aclk);
        check("input refused", {31'h0, s_pix_ready}, 32'h0);
        check("output held", {31'h0, m_pix_valid}, 32'h1);
        mode = 2'h0;
      end
    join
    give_verdict();
  end
endmodule : eef_top_tb_top
